// ---- hw/actuator_cmd_pkg.sv ----
package actuator_cmd_pkg;

  // Command word bit positions
  localparam int CMD_STOP        = 0;
  localparam int CMD_CLOSE       = 1;
  localparam int CMD_OPEN        = 2;
  localparam int CMD_ESD         = 3;
  localparam int CMD_POS_ENABLE  = 4;
  localparam int CMD_PART_STROKE = 5;
  localparam logic [15:0] CMD_USED_MASK = 16'h003F;
  localparam logic [15:0] CMD_POSITION  = 16'h0010;

  // Position demand, per mille of travel
  localparam int          DEMAND_W   = 10;
  localparam logic [15:0] DEMAND_MAX = 16'h03E8;
  localparam logic [9:0]  DEMAND_ZERO = 10'h000;
  localparam logic [9:0]  DEMAND_FULL = 10'h3E8;
  // Two percent of travel for clearing obstructed and jammed
  localparam logic [9:0]  MOVE_CLEAR_DELTA = 10'h014;

  // Relay and port words
  localparam int          RELAY_N       = 4;
  localparam logic [15:0] PORT_MIN      = 16'h0001;
  localparam logic [15:0] PORT_MAX      = 16'h000A;
  localparam int          PORT_W        = 4;

  // Status word 0 bits driven by this block
  localparam int ST0_OBSTRUCTED = 10;
  localparam int ST0_JAMMED     = 11;
  localparam int ST0_POSITIONING = 14;
  // Status word 1 reserved bit
  localparam int ST1_RESERVED   = 9;
  // Status word 0 board bits used by the command logic
  localparam int ST0_CLOSE_LIMIT = 1;
  localparam int ST0_OPEN_LIMIT  = 2;

  // Status stream: two 16-bit words, MSB first
  localparam int          STREAM_W    = 32;
  localparam logic [4:0]  STREAM_LAST = 5'h1F;

  // Active command
  typedef enum logic [6:0] {
    ACT_IDLE   = 7'b0000001,
    ACT_STOP   = 7'b0000010,
    ACT_CLOSE  = 7'b0000100,
    ACT_OPEN   = 7'b0001000,
    ACT_ESD    = 7'b0010000,
    ACT_POS    = 7'b0100000,
    ACT_STROKE = 7'b1000000
  } action_t;

endpackage

// ---- hw/actuator_cmd_ctrl.sv ----
// Operation
// - Command bits: stop, close, open, emergency, position enable, partial stroke; rest reserved.
// - An accepted single-bit command starts its action and replaces the previous one.
// - Command words with several of bits 0 to 5 set are ignored whole; action stays unchanged.
// - Demand 0 to 1000 maps linearly to 0.0 to 100.0 percent travel.
// - Position enable drives toward the current demand and cancels other commands.
// - Without limited range, 0% demand means full close, 100% full open.
// - With limited range, 0% at closed limit and 100% at open are ignored.
// - Relay word bits 0 to 3 drive four relays; one energises, zero releases.
// - Relays hold while power is off and are released when power returns.
// - Port selection only in configuration ten, values one to ten select ports.
// - A changed port word moves to that port; return to remote re-adopts it.
// - Without selector variant, network disable plus emergency input blocks network motion commands, no emergency function.
// - Selector variant accepts network commands only while the selector is in run.
// - Variant acts on latest command; priority emergency, close, open, stop, positioning.
// - Status streams word 0 bit 15 to 0, then word 1 bit 15 to 0.
// - Status word 0 carries motion, limits, selector, alarm and positioning indications.
// - Status word 1 low byte carries battery, interlocks, auxiliary inputs, slow mode.
// - Status word 1 high byte carries configuration, contention, stroke and redundancy flags.
// - Slow mode bit is reported only and never changes actuator motion.
// - Positioning tracks demand updates and ends when another command bit is written.
// - Obstructed and jammed stay set until position moves by two percent.
`timescale 1ns/1ps

module actuator_cmd_ctrl
  import actuator_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic                I_CLK,
  input  wire logic                I_RST_N,
  // Cyclic output words from the fieldbus side
  input  wire logic                i_CMD_WR,
  input  wire logic [15:0]         i_CMD_WORD,
  input  wire logic                i_DEMAND_WR,
  input  wire logic [15:0]         i_DEMAND_WORD,
  input  wire logic                i_RELAY_WR,
  input  wire logic [15:0]         i_RELAY_WORD,
  input  wire logic                i_PORT_WR,
  input  wire logic [15:0]         i_PORT_WORD,
  // Parameterisation, same clock
  input  wire logic                i_NET_DISABLE,
  input  wire logic                i_SELECTOR_VARIANT,
  input  wire logic                i_LIMITED_RANGE,
  input  wire logic                i_CONFIG_TEN,
  // Actuator main board pins
  input  wire logic                i_REMOTE,
  input  wire logic                i_ESD_INPUT,
  input  wire logic                i_POWER_OK,
  input  wire logic                i_OBSTRUCT_EVT,
  input  wire logic                i_JAM_EVT,
  input  wire logic [DEMAND_W-1:0] i_POSITION,
  input  wire logic [15:0]         i_BOARD_STATUS0,
  input  wire logic [15:0]         i_BOARD_STATUS1,
  // Actuator commands
  output logic                     o_DRIVE_ESD,
  output logic                     o_DRIVE_CLOSE,
  output logic                     o_DRIVE_OPEN,
  output logic                     o_DRIVE_STOP,
  output logic                     o_POSITION_ACTIVE,
  output logic [DEMAND_W-1:0]      o_POSITION_TARGET,
  output logic                     o_PART_STROKE,
  output logic [RELAY_N-1:0]       o_RELAY,
  output logic [PORT_W-1:0]        o_PORT_TARGET,
  output logic                     o_PORT_GO,
  // Status towards the fieldbus side
  output logic [15:0]              o_STATUS_WORD0,
  output logic [15:0]              o_STATUS_WORD1,
  output logic                     o_STATUS_BIT,
  output logic                     o_STATUS_FRAME
);

  typedef struct packed {
    // Pin synchronisers, first and second stage
    logic                remote_s1;
    logic                remote_s2;
    logic                esd_s1;
    logic                esd_s2;
    logic                power_s1;
    logic                power_s2;
    logic                obst_s1;
    logic                obst_s2;
    logic                jam_s1;
    logic                jam_s2;
    logic [DEMAND_W-1:0] pos_s1;
    logic [DEMAND_W-1:0] pos_s2;
    logic [15:0]         st0_s1;
    logic [15:0]         st0_s2;
    logic [15:0]         st1_s1;
    logic [15:0]         st1_s2;
    // Edge history
    logic                remote_prev;
    logic                power_prev;
    // Command state
    action_t             action;
    logic [DEMAND_W-1:0] demand;
    logic [RELAY_N-1:0]  relay;
    logic [PORT_W-1:0]   port;
    logic                port_go;
    logic                obstructed;
    logic                jammed;
    logic [DEMAND_W-1:0] ref_pos;
    // Resolved drive outputs
    logic                drv_esd;
    logic                drv_close;
    logic                drv_open;
    logic                drv_stop;
    logic                drv_pos;
    logic [DEMAND_W-1:0] drv_target;
    logic                drv_stroke;
    // Status
    logic [15:0]         status0;
    logic [15:0]         status1;
    logic [STREAM_W-1:0] stream;
    logic [4:0]          stream_cnt;
    logic                stream_bit;
    logic                stream_frame;
  } state_t;

  state_t q;
  state_t next_q;

  function automatic logic is_onehot(input logic [15:0] w);
    return (w != 16'h0000) && ((w & (w - 16'h0001)) == 16'h0000);
  endfunction

  function automatic logic [DEMAND_W-1:0] abs_diff(input logic [DEMAND_W-1:0] a,
                                                  input logic [DEMAND_W-1:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction

  logic [15:0]   cmd_used;
  logic          net_allowed;
  logic          net_blocked;
  logic          hw_esd;
  logic          at_closed;
  logic          at_open;
  logic          pos_close;
  logic          pos_open;
  logic          pos_run;
  logic          moved_enough;
  logic [PORT_W-1:0] port_new;

  always_comb begin
    next_q = q;

    // Two-stage synchronisers for actuator board pins
    next_q.remote_s1 = i_REMOTE;
    next_q.remote_s2 = q.remote_s1;
    next_q.esd_s1    = i_ESD_INPUT;
    next_q.esd_s2    = q.esd_s1;
    next_q.power_s1  = i_POWER_OK;
    next_q.power_s2  = q.power_s1;
    next_q.obst_s1   = i_OBSTRUCT_EVT;
    next_q.obst_s2   = q.obst_s1;
    next_q.jam_s1    = i_JAM_EVT;
    next_q.jam_s2    = q.jam_s1;
    // Multi-bit pins are slow levels; a skewed sample lasts one cycle only
    next_q.pos_s1    = i_POSITION;
    next_q.pos_s2    = q.pos_s1;
    next_q.st0_s1    = i_BOARD_STATUS0;
    next_q.st0_s2    = q.st0_s1;
    next_q.st1_s1    = i_BOARD_STATUS1;
    next_q.st1_s2    = q.st1_s1;
    next_q.remote_prev = q.remote_s2;
    next_q.power_prev  = q.power_s2;

    at_closed = q.st0_s2[ST0_CLOSE_LIMIT];
    at_open   = q.st0_s2[ST0_OPEN_LIMIT];

    net_blocked = i_NET_DISABLE && !i_SELECTOR_VARIANT && q.esd_s2;
    hw_esd = q.esd_s2 && !(i_NET_DISABLE && !i_SELECTOR_VARIANT);
    net_allowed = q.remote_s2 && !net_blocked;

    cmd_used = i_CMD_WORD & CMD_USED_MASK;

    if (i_CMD_WR && net_allowed && is_onehot(cmd_used)) begin
      unique case (1'b1)
        cmd_used[CMD_STOP]:        next_q.action = ACT_STOP;
        cmd_used[CMD_CLOSE]:       next_q.action = ACT_CLOSE;
        cmd_used[CMD_OPEN]:        next_q.action = ACT_OPEN;
        cmd_used[CMD_ESD]:         next_q.action = ACT_ESD;
        cmd_used[CMD_POS_ENABLE]:  next_q.action = ACT_POS;
        cmd_used[CMD_PART_STROKE]: next_q.action = ACT_STROKE;
        default:                   next_q.action = q.action;
      endcase
    end

    if (i_DEMAND_WR && (i_DEMAND_WORD <= DEMAND_MAX)) begin
      next_q.demand = i_DEMAND_WORD[DEMAND_W-1:0];
    end

    pos_close = (q.action == ACT_POS) && !i_LIMITED_RANGE && (q.demand == DEMAND_ZERO);
    pos_open  = (q.action == ACT_POS) && !i_LIMITED_RANGE && (q.demand == DEMAND_FULL);
    pos_run = (q.action == ACT_POS) && !pos_close && !pos_open
              && !(i_LIMITED_RANGE && (q.demand == DEMAND_ZERO) && at_closed)
              && !(i_LIMITED_RANGE && (q.demand == DEMAND_FULL) && at_open);

    next_q.drv_esd    = (q.action == ACT_ESD) || hw_esd;
    next_q.drv_close  = !next_q.drv_esd && ((q.action == ACT_CLOSE) || pos_close);
    next_q.drv_open   = !next_q.drv_esd && !next_q.drv_close
                        && ((q.action == ACT_OPEN) || pos_open);
    next_q.drv_stop   = !next_q.drv_esd && !next_q.drv_close && !next_q.drv_open
                        && (q.action == ACT_STOP);
    next_q.drv_pos    = !next_q.drv_esd && !next_q.drv_close && !next_q.drv_open
                        && !next_q.drv_stop && pos_run;
    next_q.drv_target = q.demand;
    next_q.drv_stroke = !next_q.drv_esd && (q.action == ACT_STROKE);

    if (q.power_s2 && !q.power_prev) begin
      next_q.relay = '0;
    end else if (i_RELAY_WR && q.power_s2) begin
      next_q.relay = i_RELAY_WORD[RELAY_N-1:0];
    end

    next_q.port_go = 1'b0;
    port_new = i_PORT_WORD[PORT_W-1:0];
    if (i_PORT_WR && i_CONFIG_TEN && net_allowed
        && (i_PORT_WORD >= PORT_MIN) && (i_PORT_WORD <= PORT_MAX)) begin
      if (port_new != q.port) begin
        next_q.port    = port_new;
        next_q.port_go = 1'b1;
      end
    end
    if (i_CONFIG_TEN && q.remote_s2 && !q.remote_prev && (q.port != '0)) begin
      next_q.port_go = 1'b1;
    end

    moved_enough = abs_diff(q.pos_s2, q.ref_pos) >= MOVE_CLEAR_DELTA;
    if (moved_enough) begin
      next_q.obstructed = 1'b0;
      next_q.jammed     = 1'b0;
    end
    // New events win over the clear in the same cycle
    if (q.obst_s2) begin
      next_q.obstructed = 1'b1;
    end
    if (q.jam_s2) begin
      next_q.jammed = 1'b1;
    end
    if (q.obst_s2 || q.jam_s2 || !(q.obstructed || q.jammed)) begin
      next_q.ref_pos = q.pos_s2;
    end

    next_q.status0 = q.st0_s2;
    next_q.status0[ST0_OBSTRUCTED]  = q.obstructed;
    next_q.status0[ST0_JAMMED]      = q.jammed;
    next_q.status0[ST0_POSITIONING] = q.drv_pos;
    next_q.status1 = q.st1_s2;
    next_q.status1[ST1_RESERVED] = 1'b0;

    next_q.stream_frame = 1'b0;
    if (q.stream_cnt == STREAM_LAST) begin
      next_q.stream       = {q.status0, q.status1};
      next_q.stream_cnt   = '0;
      next_q.stream_frame = 1'b1;
    end else begin
      next_q.stream     = {q.stream[STREAM_W-2:0], 1'b0};
      next_q.stream_cnt = q.stream_cnt + 5'h01;
    end
    next_q.stream_bit = (q.stream_cnt == STREAM_LAST) ? q.status0[15]
                                                      : q.stream[STREAM_W-2];
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q        <= '0;
      q.action <= ACT_IDLE;
      // First frame starts on the first edge after release
      q.stream_cnt <= STREAM_LAST;
    end else begin
      q <= next_q;
    end
  end

  assign o_DRIVE_ESD       = q.drv_esd;
  assign o_DRIVE_CLOSE     = q.drv_close;
  assign o_DRIVE_OPEN      = q.drv_open;
  assign o_DRIVE_STOP      = q.drv_stop;
  assign o_POSITION_ACTIVE = q.drv_pos;
  assign o_POSITION_TARGET = q.drv_target;
  assign o_PART_STROKE     = q.drv_stroke;
  assign o_RELAY           = q.relay;
  assign o_PORT_TARGET     = q.port;
  assign o_PORT_GO         = q.port_go;
  assign o_STATUS_WORD0    = q.status0;
  assign o_STATUS_WORD1    = q.status1;
  assign o_STATUS_BIT      = q.stream_bit;
  assign o_STATUS_FRAME    = q.stream_frame;

endmodule // actuator_cmd_ctrl

// ---- verif/fieldbus_master_model.sv ----
`timescale 1ns/1ps
module fieldbus_master_model
  import actuator_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  // Serial status from the device
  input  wire logic   i_bit,
  input  wire logic   i_frame,
  // Received status words
  output logic [15:0] o_word0,
  output logic [15:0] o_word1,
  output logic        o_valid
);
  logic [STREAM_W-1:0] shift;
  logic [5:0]          cnt;
  // first bit is word 0 bit 15
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift   <= '0;
      cnt     <= 6'h00;
      o_valid <= 1'b0;
    end else begin
      shift   <= {shift[STREAM_W-2:0], i_bit};
      cnt     <= i_frame ? 6'h01 : cnt + 6'h01;
      // Whole frame in hand after the 32nd bit
      o_valid <= (cnt == 6'h1F);
    end
  end
  assign o_word0 = shift[31:16];
  assign o_word1 = shift[15:0];
endmodule // fieldbus_master_model

// ---- verif/actuator_cmd_chk.sv ----
`timescale 1ns/1ps
module actuator_cmd_chk
  import actuator_cmd_pkg::*;
(
  // Clock and reset
  input wire logic                I_CLK,
  input wire logic                I_RST_N,
  // Writes and pins
  input wire logic                i_CMD_WR,
  input wire logic [15:0]         i_CMD_WORD,
  input wire logic                i_DEMAND_WR,
  input wire logic [15:0]         i_DEMAND_WORD,
  input wire logic                i_RELAY_WR,
  input wire logic [15:0]         i_RELAY_WORD,
  input wire logic                i_PORT_WR,
  input wire logic [15:0]         i_PORT_WORD,
  input wire logic                i_CONFIG_TEN,
  input wire logic                i_REMOTE,
  input wire logic                i_ESD_INPUT,
  input wire logic                i_POWER_OK,
  // Outputs
  input wire logic                o_DRIVE_ESD,
  input wire logic                o_DRIVE_CLOSE,
  input wire logic                o_DRIVE_OPEN,
  input wire logic                o_DRIVE_STOP,
  input wire logic [DEMAND_W-1:0] o_POSITION_TARGET,
  input wire logic [RELAY_N-1:0]  o_RELAY,
  input wire logic [PORT_W-1:0]   o_PORT_TARGET,
  input wire logic                o_PORT_GO,
  input wire logic                o_STATUS_FRAME
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  logic [15:0] cmd_m;
  logic [3:0]  drv;
  assign cmd_m = i_CMD_WORD & CMD_USED_MASK;
  assign drv = {o_DRIVE_ESD, o_DRIVE_CLOSE, o_DRIVE_OPEN, o_DRIVE_STOP};
  // Pins settled long enough for the synchronisers
  sequence ready_s;
    (i_REMOTE && !i_ESD_INPUT)[*6];
  endsequence
  drive_excl_a: assert property ($onehot0(drv))
    else $error("drive outputs overlap");
  open_cmd_a: assert property ((ready_s ##0 (i_CMD_WR && cmd_m == 16'h0004))
    |-> ##2 o_DRIVE_OPEN) else $error("open command not applied");
  esd_cmd_a: assert property ((ready_s ##0 (i_CMD_WR && cmd_m == 16'h0008))
    |-> ##2 o_DRIVE_ESD) else $error("emergency command not applied");
  multi_ign_a: assert property ((i_CMD_WR && !$onehot(cmd_m)) |-> ##2 $stable(drv))
    else $error("bad command word changed drives");
  demand_take_a: assert property ((i_DEMAND_WR && i_DEMAND_WORD <= DEMAND_MAX)
    |-> ##2 o_POSITION_TARGET == $past(i_DEMAND_WORD[DEMAND_W-1:0], 2))
    else $error("demand not taken");
  relay_wr_a: assert property ((i_POWER_OK[*6] ##0 i_RELAY_WR)
    |=> o_RELAY == $past(i_RELAY_WORD[RELAY_N-1:0])) else $error("relay write lost");
  relay_clr_a: assert property ($rose(i_POWER_OK) |-> ##[1:6] (o_RELAY == '0))
    else $error("relays not released on power return");
  port_take_a: assert property ((ready_s ##0 (i_PORT_WR && i_CONFIG_TEN
    && i_PORT_WORD inside {[PORT_MIN:PORT_MAX]} && i_PORT_WORD[PORT_W-1:0] != o_PORT_TARGET))
    |=> o_PORT_GO && o_PORT_TARGET == $past(i_PORT_WORD[PORT_W-1:0]))
    else $error("port move not issued");
  frame_per_a: assert property (o_STATUS_FRAME |-> ##32 o_STATUS_FRAME)
    else $error("status frame period wrong");
  cover property (o_PORT_GO);
  cover property (o_DRIVE_ESD);
  cover property (i_RELAY_WR && !i_POWER_OK);
endmodule // actuator_cmd_chk

bind actuator_cmd_ctrl actuator_cmd_chk u_actuator_cmd_chk (.*);

// ---- verif/actuator_cmd_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (e)); \
  end \
end
module actuator_cmd_ctrl_tb_top
  import actuator_cmd_pkg::*;
;
  logic I_CLK = 1'b0, I_RST_N = 1'b0, close_lim, rx_ok;
  logic i_CMD_WR, i_DEMAND_WR, i_RELAY_WR, i_PORT_WR, i_OBSTRUCT_EVT, i_JAM_EVT;
  logic i_NET_DISABLE, i_SELECTOR_VARIANT, i_LIMITED_RANGE, i_CONFIG_TEN;
  logic i_REMOTE, i_ESD_INPUT, i_POWER_OK, o_PORT_GO, o_STATUS_BIT, o_STATUS_FRAME;
  logic o_DRIVE_ESD, o_DRIVE_CLOSE, o_DRIVE_OPEN, o_DRIVE_STOP, o_POSITION_ACTIVE, o_PART_STROKE;
  logic [15:0] i_CMD_WORD, i_DEMAND_WORD, i_RELAY_WORD, i_PORT_WORD, rx0, rx1;
  logic [15:0] i_BOARD_STATUS0, i_BOARD_STATUS1, o_STATUS_WORD0, o_STATUS_WORD1;
  logic [DEMAND_W-1:0] i_POSITION, o_POSITION_TARGET;
  logic [RELAY_N-1:0]  o_RELAY;
  logic [PORT_W-1:0]   o_PORT_TARGET;
  logic [5:0]          drv;
  logic [5:0]          exp_drv [6] = '{6'h04, 6'h10, 6'h08, 6'h20, 6'h02, 6'h01};
  // Pin knobs: jam, obstruct, close limit, net disable, variant, limited, config, remote, esd, power
  logic [9:0]          knobs = 10'h005;
  int                  miscompares = 0, total_checks = 0, cycles = 0, go_cnt = 0;
  assign {i_JAM_EVT, i_OBSTRUCT_EVT, close_lim, i_NET_DISABLE, i_SELECTOR_VARIANT,
          i_LIMITED_RANGE, i_CONFIG_TEN, i_REMOTE, i_ESD_INPUT, i_POWER_OK} = knobs;
  // Board bits 10 and 11 set so the alarm overrides are visible
  assign i_BOARD_STATUS0 = {14'h2308, close_lim, 1'b1};
  assign drv = {o_DRIVE_ESD, o_DRIVE_CLOSE, o_DRIVE_OPEN, o_DRIVE_STOP, o_POSITION_ACTIVE,
                o_PART_STROKE};
  actuator_cmd_ctrl u_actuator_cmd_ctrl (.*);
  fieldbus_master_model u_fieldbus_master_model (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_bit   (o_STATUS_BIT),
    .i_frame (o_STATUS_FRAME),
    .o_word0 (rx0),
    .o_word1 (rx1),
    .o_valid (rx_ok)
  );
  always #25 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    cycles++;
    if (o_PORT_GO === 1'b1) go_cnt++;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask
  task automatic set(input logic [9:0] k);
    @(posedge I_CLK);
    knobs <= k;
    cyc(6);
  endtask
  // Sel: 0 command, 1 demand, 2 relay, 3 port
  task automatic wr(input int sel, input logic [15:0] v);
    @(posedge I_CLK);
    i_CMD_WORD    <= v;
    i_DEMAND_WORD <= v;
    i_RELAY_WORD  <= v;
    i_PORT_WORD   <= v;
    {i_PORT_WR, i_RELAY_WR, i_DEMAND_WR, i_CMD_WR} <= 4'h1 << sel;
    @(posedge I_CLK);
    {i_PORT_WR, i_RELAY_WR, i_DEMAND_WR, i_CMD_WR} <= 4'h0;
    cyc(5);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {i_CMD_WR, i_DEMAND_WR, i_RELAY_WR, i_PORT_WR} = 4'h0;
    {i_CMD_WORD, i_DEMAND_WORD, i_RELAY_WORD, i_PORT_WORD} = '0;
    i_POSITION = 10'h064;
    i_BOARD_STATUS1 = 16'h0FFF;
    repeat (6) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    // Early frames still carry pre-sync zeros
    repeat (3) @(posedge rx_ok);
    #1;
    `CHK(rx0, 16'h8021)
    `CHK(rx1, 16'h0DFF)
    `CHK(o_STATUS_WORD0, 16'h8021)
    `CHK(o_STATUS_WORD1, 16'h0DFF)
    $display("test status done");
    // demand loaded before any position command
    wr(1, 16'h01F4);
    foreach (exp_drv[b]) begin
      wr(0, 16'hFFC0 | (16'h0001 << b));
      `CHK(drv, exp_drv[b])
    end
    wr(0, 16'h0006);
    `CHK(drv, 6'h01)
    wr(0, 16'h0000);
    `CHK(drv, 6'h01)
    $display("test commands done");
    wr(0, CMD_POSITION);
    `CHK(drv, 6'h02)
    `CHK(o_STATUS_WORD0[ST0_POSITIONING], 1'b1)
    `CHK(o_POSITION_TARGET, 10'h1F4)
    wr(1, 16'h0000);
    `CHK(drv, 6'h10)
    wr(1, DEMAND_MAX);
    `CHK(drv, 6'h08)
    wr(1, 16'h03E9);
    `CHK(o_POSITION_TARGET, DEMAND_FULL)
    set(10'h095);
    wr(1, 16'h0000);
    `CHK(drv, 6'h00)
    set(10'h005);
    $display("test positioning done");
    wr(0, 16'h0004);
    set(10'h007);
    `CHK(drv, 6'h20)
    set(10'h047);
    `CHK(drv, 6'h08)
    wr(0, 16'h0002);
    `CHK(drv, 6'h08)
    set(10'h021);
    wr(0, 16'h0002);
    `CHK(drv, 6'h08)
    set(10'h025);
    wr(0, 16'h0002);
    `CHK(drv, 6'h10)
    wr(0, 16'h0008);
    `CHK(drv, 6'h20)
    wr(0, 16'h0001);
    `CHK(drv, 6'h04)
    // Selector variant keeps the emergency input despite net disable
    set(10'h067);
    `CHK(drv, 6'h20)
    set(10'h005);
    $display("test priority done");
    wr(2, 16'hFFF5);
    `CHK(o_RELAY, 4'h5)
    set(10'h004);
    wr(2, 16'h000A);
    `CHK(o_RELAY, 4'h5)
    set(10'h005);
    `CHK(o_RELAY, 4'h0)
    $display("test relays done");
    wr(3, 16'h0003);
    `CHK(o_PORT_TARGET, 4'h0)
    set(10'h00D);
    wr(3, 16'h0003);
    `CHK(o_PORT_TARGET, 4'h3)
    wr(3, 16'h0000);
    wr(3, 16'h000B);
    `CHK(o_PORT_TARGET, 4'h3)
    wr(3, PORT_MAX);
    `CHK(o_PORT_TARGET, 4'hA)
    set(10'h009);
    set(10'h00D);
    `CHK(go_cnt, 3)
    $display("test ports done");
    set(10'h30D);
    set(10'h00D);
    `CHK(o_STATUS_WORD0[11:10], 2'h3)
    // Just under two percent of travel
    @(posedge I_CLK);
    i_POSITION <= 10'h077;
    cyc(8);
    `CHK(o_STATUS_WORD0[11:10], 2'h3)
    @(posedge I_CLK);
    i_POSITION <= 10'h078;
    cyc(8);
    `CHK(o_STATUS_WORD0[11:10], 2'h0)
    $display("test alarms done");
    close_out();
  end
endmodule // actuator_cmd_ctrl_tb_top
